// *** pkg/gslc_pkg.sv ***
// constants, register map and types for the status lamp controller
package gslc_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_FREQ_HZ       = 50_000_000;
  localparam int unsigned BLINK_HALF_MS     = 250;
  localparam int unsigned BLINK_HALF_CYCLES = CLK_FREQ_HZ / 1000 * BLINK_HALF_MS;

  // ----------------------------------------------------------------
  // sequence counts and thresholds
  // ----------------------------------------------------------------
  // three repeats: the lamp-test counter runs 0..2, the startup blink count reaches 3
  localparam logic [1:0]  REPEAT_LAST    = 2'h2;
  localparam logic [1:0]  TEST_STEP_LAST = 2'h2;
  localparam logic [15:0] BER_LIMIT      = 16'h0096;
  // residual limit in decimetres, 100 = 10.0 m
  localparam logic [15:0] LIMIT_RESET    = 16'h0064;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_LIMIT     = 8'h00;
  localparam logic [7:0] ADDR_LAMP      = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT  = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK  = 8'h0C;
  localparam logic [3:0] IRQ_MASK_RESET = 4'h0;

  // lamp state register fields
  localparam int unsigned LAMP_SUPPLY_BIT = 0;
  localparam int unsigned LAMP_FIX_BIT    = 1;
  localparam int unsigned LAMP_CORR_BIT   = 2;
  localparam int unsigned LAMP_DFIX_BIT   = 3;
  localparam int unsigned LAMP_SEQ_POS    = 4;
  localparam int unsigned LAMP_PHASE_BIT  = 6;

  // interrupt status / mask fields
  localparam int unsigned IRQ_READY_BIT     = 0;
  localparam int unsigned IRQ_FIX_GAIN_BIT  = 1;
  localparam int unsigned IRQ_FIX_LOSS_BIT  = 2;
  localparam int unsigned IRQ_CORR_CHG_BIT  = 3;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SEQ_STARTUP_BLINK = 2'b00,
    SEQ_LAMP_TEST     = 2'b01,
    SEQ_RUN           = 2'b10
  } gslc_seq_type;

  typedef enum logic [2:0] {
    SEL_LIMIT     = 3'b000,
    SEL_LAMP      = 3'b001,
    SEL_IRQ_STAT  = 3'b010,
    SEL_IRQ_MASK  = 3'b011,
    SEL_NONE      = 3'b100
  } gslc_sel_type;

endpackage

// *** rtl/gslc_top.sv ***
// front panel status lamp controller with AXI4-Lite registers
//
// Notes on behaviour
// R1: supply lamp lit steadily while running
// R2: fix lamp blinks first after power-up
// R3: lamp test runs three lamps in sequence
// R4: solid fix lock keeps fix lamp lit
// R5: missing fix lock keeps fix lamp blinking
// R6: correction lamp lit on good link/external corrections
// R7: locked link with high error rate blinks
// R8: corrected fix lamp steady below residual limit
// R9: residual limit resets to 10.0 m, writable
// R10: residual above limit blinks corrected fix lamp
// R11: corrected fix needs fix, correction, applied
// R12: all blinking shares one 2 Hz divider
// R13: startup blink and test repeat three times
`timescale 1ns/1ps

module gslc_top
  import gslc_pkg::*;
#(
  parameter int unsigned HALF_CYCLES = BLINK_HALF_CYCLES
) (
  input  wire logic        CLOCK,
  input  wire logic        RST_N,
  input  wire logic        FIX_LOCK,
  input  wire logic        LINK_LOCK,
  input  wire logic [15:0] LINK_BER,
  input  wire logic        EXT_CORR_OK,
  input  wire logic        CORRECTION_LOCK_LAMP_SOLUTION,
  input  wire logic        CORR_APPLIED,
  input  wire logic [15:0] RESIDUAL,
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  output logic             SUPPLY_LAMP,
  output logic             FIX_LOCK_LAMP,
  output logic             CORRECTION_LOCK_LAMP,
  output logic             CORRECTED_FIX_LAMP,
  output logic             IRQ
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic gslc_sel_type decode(input logic [7:0] addr);
    unique case (addr)
      ADDR_LIMIT:    decode = SEL_LIMIT;
      ADDR_LAMP:     decode = SEL_LAMP;
      ADDR_IRQ_STAT: decode = SEL_IRQ_STAT;
      ADDR_IRQ_MASK: decode = SEL_IRQ_MASK;
      default:       decode = SEL_NONE;
    endcase
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    merge = res;
  endfunction

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [31:0]  div_cnt;
  logic [31:0]  next_div_cnt;
  logic         tick;
  logic         blink_phase;
  logic         next_blink_phase;
  gslc_seq_type seq_state;
  gslc_seq_type next_seq_state;
  logic [1:0]   rep_cnt;
  logic [1:0]   next_rep_cnt;
  logic [1:0]   test_step;
  logic [1:0]   next_test_step;
  logic         fix_seen;
  logic         next_fix_seen;
  logic         corr_seen;
  logic         next_corr_seen;
  logic [3:0]   lamps;
  logic [3:0]   next_lamps;
  logic         corr_lock;
  logic         seq_done;

  logic         aw_full;
  logic         next_aw_full;
  logic [7:0]   aw_addr;
  logic [7:0]   next_aw_addr;
  logic         w_full;
  logic         next_w_full;
  logic [31:0]  w_data;
  logic [31:0]  next_w_data;
  logic [3:0]   w_strb;
  logic [3:0]   next_w_strb;
  logic         bvalid;
  logic         next_bvalid;
  logic [1:0]   bresp;
  logic [1:0]   next_bresp;
  logic         rvalid;
  logic         next_rvalid;
  logic [31:0]  rdata;
  logic [31:0]  next_rdata;
  logic [1:0]   rresp;
  logic [1:0]   next_rresp;
  logic         do_write;
  gslc_sel_type wr_sel;

  logic [15:0]  limit;
  logic [15:0]  next_limit;
  logic [3:0]   irq_mask;
  logic [3:0]   next_irq_mask;
  logic [3:0]   irq_stat;
  logic [3:0]   next_irq_stat;
  logic [3:0]   irq_event;
  logic [3:0]   irq_clear;
  logic [31:0]  merged;

  // ----------------------------------------------------------------
  // blink divider and lamp sequencer
  // ----------------------------------------------------------------
  assign tick      = (div_cnt == HALF_CYCLES - 1);
  assign corr_lock = LINK_LOCK | EXT_CORR_OK;
  assign seq_done  = (seq_state == SEQ_LAMP_TEST) && tick &&
                     (test_step == TEST_STEP_LAST) && (rep_cnt == REPEAT_LAST);

  always_comb begin
    next_div_cnt     = tick ? 32'h0000_0000 : div_cnt + 32'h0000_0001;  // [R12]
    next_blink_phase = tick ? ~blink_phase : blink_phase;                // [R12]
    next_seq_state   = seq_state;
    next_rep_cnt     = rep_cnt;
    next_test_step   = test_step;
    next_fix_seen    = FIX_LOCK;
    next_corr_seen   = corr_lock;
    next_lamps       = 4'h0;
    next_lamps[LAMP_SUPPLY_BIT] = 1'b1;  // [R1]
    unique case (seq_state)
      SEQ_STARTUP_BLINK: begin
        next_lamps[LAMP_FIX_BIT] = blink_phase;  // [R2]
        // a blink ends when the lamp goes dark; one more dark half keeps
        // the last blink from running into the first lamp-test step
        if (tick && blink_phase) begin
          next_rep_cnt = rep_cnt + 2'h1;
        end else if (tick && (rep_cnt == REPEAT_LAST + 2'h1)) begin  // [R13]
          next_seq_state = SEQ_LAMP_TEST;  // [R3]
          next_rep_cnt   = 2'h0;
          next_test_step = 2'h0;
        end
      end
      SEQ_LAMP_TEST: begin
        next_lamps[LAMP_FIX_BIT]  = (test_step == 2'h0);  // [R3]
        next_lamps[LAMP_CORR_BIT] = (test_step == 2'h1);
        next_lamps[LAMP_DFIX_BIT] = (test_step == 2'h2);
        if (tick) begin
          if (test_step == TEST_STEP_LAST) begin
            next_test_step = 2'h0;
            if (rep_cnt == REPEAT_LAST) begin  // [R13]
              next_seq_state = SEQ_RUN;
              next_rep_cnt   = 2'h0;
            end else begin
              next_rep_cnt = rep_cnt + 2'h1;
            end
          end else begin
            next_test_step = test_step + 2'h1;
          end
        end
      end
      SEQ_RUN: begin
        // a fix that never arrives leaves the lamp blinking as a fault sign
        next_lamps[LAMP_FIX_BIT] = FIX_LOCK ? 1'b1 : blink_phase;  // [R4] [R5]
        if ((LINK_LOCK && (LINK_BER < BER_LIMIT)) || EXT_CORR_OK) begin
          next_lamps[LAMP_CORR_BIT] = 1'b1;  // [R6]
        end else if (LINK_LOCK) begin
          next_lamps[LAMP_CORR_BIT] = blink_phase;  // [R7]
        end
        if (FIX_LOCK && corr_lock && CORRECTION_LOCK_LAMP_SOLUTION && CORR_APPLIED) begin  // [R11]
          next_lamps[LAMP_DFIX_BIT] = (RESIDUAL < limit) ? 1'b1 : blink_phase;  // [R8] [R10]
        end
      end
      default: begin
        next_seq_state = SEQ_STARTUP_BLINK;
      end
    endcase
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      div_cnt     <= 32'h0000_0000;
      blink_phase <= 1'b0;
      seq_state   <= SEQ_STARTUP_BLINK;
      rep_cnt     <= 2'h0;
      test_step   <= 2'h0;
      fix_seen    <= 1'b0;
      corr_seen   <= 1'b0;
      lamps       <= 4'h1;
    end else begin
      div_cnt     <= next_div_cnt;
      blink_phase <= next_blink_phase;
      seq_state   <= next_seq_state;
      rep_cnt     <= next_rep_cnt;
      test_step   <= next_test_step;
      fix_seen    <= next_fix_seen;
      corr_seen   <= next_corr_seen;
      lamps       <= next_lamps;
    end
  end

  assign SUPPLY_LAMP          = lamps[LAMP_SUPPLY_BIT];
  assign FIX_LOCK_LAMP        = lamps[LAMP_FIX_BIT];
  assign CORRECTION_LOCK_LAMP = lamps[LAMP_CORR_BIT];
  assign CORRECTED_FIX_LAMP   = lamps[LAMP_DFIX_BIT];

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  // one write and one read in flight; address and data accepted in any order
  assign S_AXI_AWREADY = !aw_full && !bvalid;
  assign S_AXI_WREADY  = !w_full && !bvalid;
  assign S_AXI_ARREADY = !rvalid;
  assign S_AXI_BVALID  = bvalid;
  assign S_AXI_BRESP   = bresp;
  assign S_AXI_RVALID  = rvalid;
  assign S_AXI_RDATA   = rdata;
  assign S_AXI_RRESP   = rresp;
  assign do_write      = aw_full && w_full && !bvalid;
  assign wr_sel        = decode(aw_addr);

  always_comb begin
    next_aw_full = aw_full;
    next_aw_addr = aw_addr;
    next_w_full  = w_full;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    next_rvalid  = rvalid;
    next_rdata   = rdata;
    next_rresp   = rresp;
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      next_aw_full = 1'b1;
      next_aw_addr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      next_w_full = 1'b1;
      next_w_data = S_AXI_WDATA;
      next_w_strb = S_AXI_WSTRB;
    end
    if (do_write) begin
      next_aw_full = 1'b0;
      next_w_full  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (bvalid && S_AXI_BREADY) begin
      next_bvalid = 1'b0;
    end
    if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      next_rvalid = 1'b1;
      next_rresp  = RESP_OKAY;
      next_rdata  = 32'h0000_0000;
      unique case (decode(S_AXI_ARADDR))
        SEL_LIMIT:    next_rdata[15:0] = limit;
        SEL_LAMP: begin
          next_rdata[3:0]                     = lamps;
          next_rdata[LAMP_SEQ_POS +: 2]       = seq_state;
          next_rdata[LAMP_PHASE_BIT]          = blink_phase;
        end
        SEL_IRQ_STAT: next_rdata[3:0] = irq_stat;
        SEL_IRQ_MASK: next_rdata[3:0] = irq_mask;
        default:      next_rresp = RESP_SLVERR;
      endcase
    end else if (rvalid && S_AXI_RREADY) begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      aw_full <= 1'b0;
      aw_addr <= 8'h00;
      w_full  <= 1'b0;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
      bvalid  <= 1'b0;
      bresp   <= RESP_OKAY;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= RESP_OKAY;
    end else begin
      aw_full <= next_aw_full;
      aw_addr <= next_aw_addr;
      w_full  <= next_w_full;
      w_data  <= next_w_data;
      w_strb  <= next_w_strb;
      bvalid  <= next_bvalid;
      bresp   <= next_bresp;
      rvalid  <= next_rvalid;
      rdata   <= next_rdata;
      rresp   <= next_rresp;
    end
  end

  // ----------------------------------------------------------------
  // residual limit and interrupt registers
  // ----------------------------------------------------------------
  always_comb begin
    merged        = 32'h0000_0000;
    next_limit    = limit;
    next_irq_mask = irq_mask;
    irq_clear     = 4'h0;
    irq_event     = 4'h0;
    irq_event[IRQ_READY_BIT]    = seq_done;
    irq_event[IRQ_FIX_GAIN_BIT] = FIX_LOCK && !fix_seen;
    irq_event[IRQ_FIX_LOSS_BIT] = !FIX_LOCK && fix_seen;
    irq_event[IRQ_CORR_CHG_BIT] = corr_lock ^ corr_seen;
    if (do_write) begin
      unique case (wr_sel)
        SEL_LIMIT: begin
          merged     = merge({16'h0000, limit}, w_data, w_strb);
          next_limit = merged[15:0];  // [R9]
        end
        SEL_IRQ_STAT: begin
          merged    = merge(32'h0000_0000, w_data, w_strb);
          irq_clear = merged[3:0];
        end
        SEL_IRQ_MASK: begin
          merged        = merge({28'h0000000, irq_mask}, w_data, w_strb);
          next_irq_mask = merged[3:0];
        end
        default: begin
          merged = 32'h0000_0000;
        end
      endcase
    end
    // a new event outranks a clear landing in the same cycle
    next_irq_stat = (irq_stat & ~irq_clear) | irq_event;
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      limit    <= LIMIT_RESET;  // [R9]
      irq_mask <= IRQ_MASK_RESET;
      irq_stat <= 4'h0;
      IRQ      <= 1'b0;
    end else begin
      limit    <= next_limit;
      irq_mask <= next_irq_mask;
      irq_stat <= next_irq_stat;
      IRQ      <= |(next_irq_stat & next_irq_mask);
    end
  end

endmodule

// *** tb/gslc_top_chk.sv ***
// assertions on the lamp outputs, bound to the lamp controller top
`timescale 1ns/1ps
module gslc_top_chk
  import gslc_pkg::*;
#(
  parameter int unsigned HALF_CYCLES = 8
) (
  input wire logic        CLOCK,
  input wire logic        RST_N,
  input wire logic        FIX_LOCK,
  input wire logic        LINK_LOCK,
  input wire logic [15:0] LINK_BER,
  input wire logic        EXT_CORR_OK,
  input wire logic        CORRECTION_LOCK_LAMP_SOLUTION,
  input wire logic        CORR_APPLIED,
  input wire logic [15:0] RESIDUAL,
  input wire logic        SUPPLY_LAMP,
  input wire logic        FIX_LOCK_LAMP,
  input wire logic        CORRECTION_LOCK_LAMP,
  input wire logic        CORRECTED_FIX_LAMP
);
  // ------------------------------------------------------------
  // helper counters
  // ------------------------------------------------------------
  int unsigned cnt;
  int unsigned sf;
  int unsigned sc;
  logic        run;
  logic        bad;
  logic        full;
  logic        fix_q;
  logic        corr_q;
  // margin of a few cycles after the end of the power-up sequence
  assign run = cnt > 16 * HALF_CYCLES + 4;
  assign bad = LINK_LOCK && LINK_BER >= BER_LIMIT && !EXT_CORR_OK;
  assign full = FIX_LOCK && (LINK_LOCK || EXT_CORR_OK) && CORRECTION_LOCK_LAMP_SOLUTION && CORR_APPLIED;
  // a frozen blink shows up as an overlong steady run
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      cnt <= 0;
      sf <= 0;
      sc <= 0;
      fix_q <= 1'b0;
      corr_q <= 1'b0;
    end else begin
      cnt <= run ? cnt : cnt + 1;
      fix_q <= FIX_LOCK_LAMP;
      corr_q <= CORRECTION_LOCK_LAMP;
      sf <= (!run || FIX_LOCK || FIX_LOCK_LAMP != fix_q) ? 0 : sf + 1;
      sc <= (!run || !bad || CORRECTION_LOCK_LAMP != corr_q) ? 0 : sc + 1;
    end
  end
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  property p_supply;
    SUPPLY_LAMP;
  endproperty
  a_supply: assert property (p_supply) else $error("supply lamp dark");
  property p_start;
    cnt >= 3 && cnt <= HALF_CYCLES - 2 |-> !FIX_LOCK_LAMP && !CORRECTION_LOCK_LAMP && !CORRECTED_FIX_LAMP;
  endproperty
  a_start: assert property (p_start) else $error("lamp lit in first dark phase");
  property p_test;
    cnt >= 7 * HALF_CYCLES + 3 && cnt <= 8 * HALF_CYCLES - 2
      |-> FIX_LOCK_LAMP && !CORRECTION_LOCK_LAMP && !CORRECTED_FIX_LAMP;
  endproperty
  a_test: assert property (p_test) else $error("lamp test does not open on fix lamp");
  property p_fix;
    run && FIX_LOCK |=> FIX_LOCK_LAMP;
  endproperty
  a_fix: assert property (p_fix) else $error("fix lamp not steady on lock");
  property p_fix_blink;
    sf <= HALF_CYCLES + 2;
  endproperty
  a_fix_blink: assert property (p_fix_blink) else $error("fix lamp stopped blinking");
  property p_corr_on;
    run && ((LINK_LOCK && LINK_BER < BER_LIMIT) || EXT_CORR_OK) |=> CORRECTION_LOCK_LAMP;
  endproperty
  a_corr_on: assert property (p_corr_on) else $error("correction lamp dark");
  property p_corr_blink;
    sc <= HALF_CYCLES + 2;
  endproperty
  a_corr_blink: assert property (p_corr_blink) else $error("marginal lock not blinking");
  property p_dfix_on;
    run && full && RESIDUAL == 16'h0000 |=> CORRECTED_FIX_LAMP;
  endproperty
  a_dfix_on: assert property (p_dfix_on) else $error("corrected fix lamp dark");
  property p_dfix_off;
    run && !full |=> !CORRECTED_FIX_LAMP;
  endproperty
  a_dfix_off: assert property (p_dfix_off) else $error("corrected fix lamp lit early");
endmodule
bind gslc_top gslc_top_chk #(.HALF_CYCLES(HALF_CYCLES)) u_chk (
  .CLOCK(CLOCK), .RST_N(RST_N), .FIX_LOCK(FIX_LOCK), .LINK_LOCK(LINK_LOCK),
  .LINK_BER(LINK_BER), .EXT_CORR_OK(EXT_CORR_OK), .CORRECTION_LOCK_LAMP_SOLUTION(CORRECTION_LOCK_LAMP_SOLUTION),
  .CORR_APPLIED(CORR_APPLIED), .RESIDUAL(RESIDUAL), .SUPPLY_LAMP(SUPPLY_LAMP),
  .FIX_LOCK_LAMP(FIX_LOCK_LAMP), .CORRECTION_LOCK_LAMP(CORRECTION_LOCK_LAMP),
  .CORRECTED_FIX_LAMP(CORRECTED_FIX_LAMP));

// *** tb/gslc_panel_view.sv ***
// operator's view of the front panel: counts flashes of three lamps
`timescale 1ns/1ps
module gslc_panel_view (
  input  wire logic        CLOCK,
  input  wire logic        RST_N,
  input  wire logic [2:0]  LAMPS,
  output logic [2:0][7:0]  FLASHES
);
  logic [2:0] prev;
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      prev <= 3'h0;
      FLASHES <= '0;
    end else begin
      prev <= LAMPS;
      for (int i = 0; i < 3; i++) begin
        if (LAMPS[i] && !prev[i]) FLASHES[i] <= FLASHES[i] + 8'h01;
      end
    end
  end
endmodule

// *** tb/gnss_status_led_controller_tb_top.sv ***
// self-checking bench for the status lamp controller
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin mismatches++; $display("unexpected %0t value", $time); end end
module gnss_status_led_controller_tb_top
  import gslc_pkg::*;
;
  localparam int unsigned H = 8;
  logic CLOCK = 1'b0, RST_N = 1'b0, FIX_LOCK = 1'b1, LINK_LOCK = 1'b0, EXT_CORR_OK = 1'b0;
  logic CORRECTION_LOCK_LAMP_SOLUTION = 1'b0, CORR_APPLIED = 1'b0;
  logic [15:0] LINK_BER = 16'h0000, RESIDUAL = 16'h0000;
  logic [7:0]  S_AXI_AWADDR = 8'h00, S_AXI_ARADDR = 8'h00;
  logic [31:0] S_AXI_WDATA = 32'h0, S_AXI_RDATA;
  logic [3:0]  S_AXI_WSTRB = 4'hF;
  logic S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0, S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0;
  logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID, IRQ;
  logic SUPPLY_LAMP, FIX_LOCK_LAMP, CORRECTION_LOCK_LAMP, CORRECTED_FIX_LAMP;
  logic [1:0]  S_AXI_BRESP, S_AXI_RRESP, r;
  logic [2:0][7:0] flashes;
  logic [31:0] d, x;
  logic [1:0]  st [3];
  logic [15:0] bers [4] = '{16'h0095, 16'h0096, 16'h0097, 16'h1234};
  logic [15:0] ress [8] = '{16'h0000, 16'h001F, 16'h0020, 16'h0021, 16'h0005, 16'h0300, 16'h001F, 16'h0021};
  int mismatches = 0;
  int num_checks = 0;
  always #10 CLOCK = ~CLOCK;
  gslc_top #(.HALF_CYCLES(H)) u_dut (.*);
  gslc_panel_view u_view (.CLOCK(CLOCK), .RST_N(RST_N), .FLASHES(flashes),
    .LAMPS({CORRECTED_FIX_LAMP, CORRECTION_LOCK_LAMP, FIX_LOCK_LAMP}));
  // ------------------------------------------------------------
  // expectations: 0 dark, 1 steady, 2 blinking
  // ------------------------------------------------------------
  function automatic logic [1:0] e_corr(logic lk, logic [15:0] ber, logic ext);
    return ((lk && ber < 16'h0096) || ext) ? 2'h1 : (lk ? 2'h2 : 2'h0);
  endfunction
  function automatic logic [1:0] e_dfix(logic fx, logic lk, logic ext, logic df, logic ap, logic [15:0] res);
    return (fx && (lk || ext) && df && ap) ? ((res < 16'h0020) ? 2'h1 : 2'h2) : 2'h0;
  endfunction
  task automatic results();
    if (mismatches == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // register bus
  // ------------------------------------------------------------
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    int n;
    @(posedge CLOCK);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= v;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge CLOCK);
      if (S_AXI_AWVALID && S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WVALID && S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
      if (S_AXI_BVALID) begin
        rs = S_AXI_BRESP;
        S_AXI_BREADY <= 1'b0;
        break;
      end
    end
    if (n == 50) begin
      mismatches++;
      results();
    end
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    int n;
    @(posedge CLOCK);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge CLOCK);
      if (S_AXI_ARVALID && S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
      if (S_AXI_RVALID) begin
        v = S_AXI_RDATA;
        rs = S_AXI_RRESP;
        S_AXI_RREADY <= 1'b0;
        break;
      end
    end
    if (n == 50) begin
      mismatches++;
      results();
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] ev, input logic [1:0] er);
    logic [31:0] v;
    logic [1:0]  rs;
    axi_rd(a, v, rs);
    `CHK(v, ev)
    `CHK(rs, er)
  endtask
  // one blink period and two cycles are enough to see a toggle
  task automatic observe(output logic [1:0] s [3]);
    logic [2:0] lo;
    logic [2:0] hi;
    lo = 3'h0;
    hi = 3'h0;
    repeat (2 * H + 2) begin
      @(posedge CLOCK);
      lo |= ~{CORRECTED_FIX_LAMP, CORRECTION_LOCK_LAMP, FIX_LOCK_LAMP};
      hi |= {CORRECTED_FIX_LAMP, CORRECTION_LOCK_LAMP, FIX_LOCK_LAMP};
    end
    for (int i = 0; i < 3; i++) s[i] = (lo[i] && hi[i]) ? 2'h2 : {1'b0, hi[i]};
  endtask
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(32'h4B3D));
    repeat (20) @(posedge CLOCK);
    `CHK(SUPPLY_LAMP, 1'b1)
    RST_N <= 1'b1;
    repeat (16 * H + 10) @(posedge CLOCK);
    `CHK(flashes[0], 8'h07)
    `CHK(flashes[1], 8'h03)
    `CHK(flashes[2], 8'h03)
    axi_rd(ADDR_IRQ_STAT, d, r);
    `CHK(d[0], 1'b1)
    `CHK(IRQ, 1'b0)
    axi_rd(ADDR_LAMP, d, r);
    `CHK(d[5:0], {SEQ_RUN, 4'h3})
    rd_chk(ADDR_LIMIT, 32'h0000_0064, RESP_OKAY);
    rd_chk(8'h10, 32'h0, RESP_SLVERR);
    axi_wr(ADDR_LIMIT, 32'h0000_0020, r);
    `CHK(r, RESP_OKAY)
    rd_chk(ADDR_LIMIT, 32'h0000_0020, RESP_OKAY);
    axi_wr(ADDR_IRQ_MASK, 32'h1, r);
    repeat (2) @(posedge CLOCK);
    `CHK(IRQ, 1'b1)
    axi_wr(ADDR_IRQ_STAT, 32'h1, r);
    repeat (2) @(posedge CLOCK);
    `CHK(IRQ, 1'b0)
    for (int k = 0; k < 32; k++) begin
      x = $urandom;
      @(posedge CLOCK);
      FIX_LOCK <= x[0];
      LINK_LOCK <= x[1];
      EXT_CORR_OK <= x[2] & x[3];
      CORRECTION_LOCK_LAMP_SOLUTION <= x[4] | x[5];
      CORR_APPLIED <= x[6] | x[7];
      LINK_BER <= (x[9:8] == 2'h3) ? x[31:16] : bers[x[9:8]];
      RESIDUAL <= ress[x[12:10]];
      repeat (3) @(posedge CLOCK);
      observe(st);
      `CHK(st[0], FIX_LOCK ? 2'h1 : 2'h2)
      `CHK(st[1], e_corr(LINK_LOCK, LINK_BER, EXT_CORR_OK))
      `CHK(st[2], e_dfix(FIX_LOCK, LINK_LOCK, EXT_CORR_OK, CORRECTION_LOCK_LAMP_SOLUTION, CORR_APPLIED, RESIDUAL))
      `CHK(SUPPLY_LAMP, 1'b1)
    end
    results();
  end
endmodule
